/* vlpa_pkg.sv */
package vlpa_pkg;

   // register offsets
   localparam logic [7:0] VLPA_LUMA_GAIN_OFS      = 8'h08;
   localparam logic [7:0] VLPA_LUMA_OFFSET_OFS    = 8'h0a;
   localparam logic [7:0] VLPA_CHROMA_PHASE_OFS   = 8'h0b;
   localparam logic [7:0] VLPA_FALLBACK_LUMA_OFS  = 8'h0c;
   localparam logic [7:0] VLPA_FALLBACK_CHROMA_OFS = 8'h0d;
   localparam logic [7:0] VLPA_LOCK_STATUS_OFS    = 8'h10;
   localparam logic [7:0] VLPA_LOCK_QUALIFY_OFS   = 8'h51;
   localparam logic [7:0] VLPA_CB_OFFSET_OFS      = 8'he1;
   localparam logic [7:0] VLPA_CR_OFFSET_OFS      = 8'he2;
   localparam logic [7:0] VLPA_CB_GAIN_OFS        = 8'he3;
   localparam logic [7:0] VLPA_CR_GAIN_OFS        = 8'he4;
   localparam logic [7:0] VLPA_VERT_COAST_OFS     = 8'hf9;

   // reset values
   localparam logic [7:0] VLPA_LUMA_GAIN_RST      = 8'h80;
   localparam logic [7:0] VLPA_LUMA_OFFSET_RST    = 8'h00;
   localparam logic [7:0] VLPA_CHROMA_PHASE_RST   = 8'h00;
   localparam logic [7:0] VLPA_FALLBACK_LUMA_RST  = 8'h36;
   localparam logic [7:0] VLPA_FALLBACK_CHROMA_RST = 8'h7c;
   localparam logic [7:0] VLPA_LOCK_QUALIFY_RST   = 8'h24;
   localparam logic [7:0] VLPA_CHROMA_OFFSET_RST  = 8'h80;
   localparam logic [7:0] VLPA_CHROMA_GAIN_RST    = 8'h80;
   localparam logic [1:0] VLPA_VERT_COAST_RST     = 2'h0;

   // field positions
   localparam int VLPA_SC_LOCK_INCLUDE_BIT = 7;
   localparam int VLPA_RAW_LOCK_SEL_BIT    = 6;
   localparam int VLPA_EXIT_COUNT_LSB      = 3;
   localparam int VLPA_ENTRY_COUNT_LSB     = 0;
   localparam int VLPA_COAST_RATE_LSB      = 2;
   localparam int VLPA_FALLBACK_LUMA_LSB   = 2;
   localparam int VLPA_FALLBACK_AUTO_BIT   = 1;
   localparam int VLPA_FALLBACK_FORCE_BIT  = 0;

   // vertical free-run rate codes
   localparam logic [1:0] VLPA_COAST_AUTO = 2'h0;
   localparam logic [1:0] VLPA_COAST_50HZ = 2'h1;
   localparam logic [1:0] VLPA_COAST_60HZ = 2'h2;

   // arithmetic constants
   localparam int VLPA_GAIN_SHIFT     = 7;
   localparam int VLPA_CHROMA_MID     = 128;
   localparam int VLPA_LUMA_OFS_MUL   = 7;
   localparam int VLPA_LUMA_OFS_SHIFT = 2;
   localparam int VLPA_TRIG_SHIFT     = 14;
   localparam int VLPA_TRIG_ONE       = 16384;
   // 0.7 degree per step, in radians scaled by 2^14
   localparam int VLPA_PHASE_STEP_Q14 = 200;

   // lines needed for a lock entry or exit code
   function automatic logic [16:0] vlpa_line_count(input logic [2:0] code);
      case (code)
         3'h0:    vlpa_line_count = 17'h00001;
         3'h1:    vlpa_line_count = 17'h00002;
         3'h2:    vlpa_line_count = 17'h00005;
         3'h3:    vlpa_line_count = 17'h0000a;
         3'h4:    vlpa_line_count = 17'h00064;
         3'h5:    vlpa_line_count = 17'h001f4;
         3'h6:    vlpa_line_count = 17'h003e8;
         default: vlpa_line_count = 17'h186a0;
      endcase
   endfunction

endpackage

/* vlpa_lock_filter.sv */
`timescale 1ns/1ps
module vlpa_lock_filter
   import vlpa_pkg::*;
(
   // clock and reset
   input  wire logic       i_clock,
   input  wire logic       i_rst_n,
   // line timing and lock condition
   input  wire logic       i_line,
   input  wire logic       i_cond,
   // programmed counts
   input  wire logic [2:0] i_entry_code,
   input  wire logic [2:0] i_exit_code,
   // qualified lock
   output logic            o_locked
);

   logic [16:0] cnt_q;
   logic [16:0] target;
   logic [16:0] last_line;
   logic        reached;

   assign target    = o_locked ? vlpa_line_count(i_exit_code) : vlpa_line_count(i_entry_code); // [RULE6] [RULE7]
   assign last_line = 17'(target - 17'h00001);
   assign reached   = (cnt_q >= last_line);

   // counts consecutive lines on which the condition differs from the state
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_q <= 17'h00000;
      end else if (i_line) begin
         if (i_cond != o_locked) begin
            if (reached) begin
               cnt_q <= 17'h00000;
            end else begin
               cnt_q <= 17'(cnt_q + 17'h00001);
            end
         end else begin
            cnt_q <= 17'h00000; // [RULE22]
         end
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_locked <= 1'b0;
      end else if (i_line && (i_cond != o_locked) && reached) begin
         o_locked <= i_cond; // [RULE5] [RULE7]
      end
   end

   entry_on_count_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RULE5]
      (!o_locked && i_line && i_cond && cnt_q >= vlpa_line_count(i_entry_code) - 17'h00001) |=> o_locked)
      else $error("lock not entered after entry count");

   entry_not_early_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RULE5]
      (!o_locked && !(i_line && i_cond && cnt_q >= vlpa_line_count(i_entry_code) - 17'h00001)) |=> !o_locked)
      else $error("lock entered before entry count");

   exit_on_count_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RULE7]
      (o_locked && i_line && !i_cond && cnt_q >= vlpa_line_count(i_exit_code) - 17'h00001) |=> !o_locked)
      else $error("lock not left after exit count");

   exit_not_early_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RULE7]
      (o_locked && !(i_line && !i_cond && cnt_q >= vlpa_line_count(i_exit_code) - 17'h00001)) |=> o_locked)
      else $error("lock left before exit count");

   count_restart_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RULE22]
      (i_line && (i_cond == o_locked)) |=> (cnt_q == 17'h00000))
      else $error("line counter not restarted");

endmodule

/* vlpa_core.sv */
// Behaviour
// RULE1: include bit clear: lock from horizontal only
// RULE2: include bit set: horizontal and subcarrier lock
// RULE3: host clears include bit for component input
// RULE4: coast code: auto, 50 Hz, 60 Hz, reserved
// RULE5: lock entered after programmed consecutive lines
// RULE6: count codes map to 1..100000 lines
// RULE7: unlock after exit count, same encoding
// RULE8: luma gain linear, 0x80 unity, 0xff double
// RULE9: blue difference gain only on Cb
// RULE10: red difference gain only on Cr
// RULE11: blue difference offset, 0x80 none
// RULE12: red difference offset, 0x80 none
// RULE13: luma offset signed, 0x7f up, 0xff down
// RULE14: chroma phase 0.7 degree steps, plus-minus 90
// RULE15: phase rotation only for AM chroma
// RULE16: fallback when auto and unlocked, or forced
// RULE17: fallback luma fills top six bits
// RULE18: fallback luma resets blue, register 0x36
// RULE19: fallback chroma nibbles fill Cr, Cb tops
// RULE20: fallback chroma resets to 0x7c
// RULE21: raw source select: time window or free-run
// RULE22: line counters restart when condition breaks
`timescale 1ns/1ps
module vlpa_core
   import vlpa_pkg::*;
(
   // clock and reset
   input  wire logic       i_clock,
   input  wire logic       i_rst_n,
   // register port
   input  wire logic [7:0] i_reg_addr,
   input  wire logic [7:0] i_reg_wdata,
   input  wire logic       i_reg_wr,
   input  wire logic       i_reg_rd,
   output logic      [7:0] o_reg_rdata,
   output logic            o_reg_rvalid,
   // lock sources from sync processing
   input  wire logic       i_line,
   input  wire logic       i_time_win,
   input  wire logic       i_free_run,
   input  wire logic       i_sc_lock,
   input  wire logic       i_last_rate_50,
   // decoded video in
   input  wire logic       i_valid,
   input  wire logic       i_am_chroma,
   input  wire logic [7:0] i_y,
   input  wire logic [7:0] i_cb,
   input  wire logic [7:0] i_cr,
   // adjusted video out
   output logic            o_valid,
   output logic      [7:0] o_y,
   output logic      [7:0] o_cb,
   output logic      [7:0] o_cr,
   // status
   output logic            o_locked,
   output logic            o_fallback_active,
   output logic            o_vs_rate_50
);

   logic [7:0] luma_gain_q;
   logic [7:0] luma_offset_q;
   logic [7:0] chroma_phase_q;
   logic [7:0] fallback_luma_q;
   logic [7:0] fallback_chroma_q;
   logic [7:0] lock_qualify_q;
   logic [7:0] cb_offset_q;
   logic [7:0] cr_offset_q;
   logic [7:0] cb_gain_q;
   logic [7:0] cr_gain_q;
   logic [1:0] vertical_freerun_rate_q;

   logic       horizontal_lock_flag;
   logic       lock_cond;
   logic       locked;
   logic       fallback_sel;
   logic       fallback_auto_enable;
   logic       fallback_force_enable;
   logic       subcarrier_lock_include;
   logic       raw_lock_source_select;
   logic [5:0] fallback_luma;
   logic [7:0] status_val;
   logic [7:0] rdata_d;

   logic [31:0]        trig;
   logic signed [31:0] cos_v;
   logic signed [31:0] sin_v;
   logic signed [31:0] cb_c;
   logic signed [31:0] cr_c;
   logic signed [31:0] cb_r;
   logic signed [31:0] cr_r;
   logic signed [31:0] y_s;
   logic signed [31:0] cb_s;
   logic signed [31:0] cr_s;
   logic [7:0]         y_d;
   logic [7:0]         cb_d;
   logic [7:0]         cr_d;

   // cos and sin of minus the phase step count, scaled by 2^14, as {cos, sin}
   function automatic logic [31:0] vlpa_trig(input logic [7:0] code);
      longint a;
      longint a2;
      longint a3;
      longint a4;
      longint a5;
      longint a6;
      longint s;
      longint c;
      a  = -longint'(signed'(code)) * longint'(VLPA_PHASE_STEP_Q14);
      a2 = (a * a) >>> VLPA_TRIG_SHIFT;
      a3 = (a2 * a) >>> VLPA_TRIG_SHIFT;
      a4 = (a2 * a2) >>> VLPA_TRIG_SHIFT;
      a5 = (a4 * a) >>> VLPA_TRIG_SHIFT;
      a6 = (a3 * a3) >>> VLPA_TRIG_SHIFT;
      s  = a - a3 / 6 + a5 / 120;
      c  = longint'(VLPA_TRIG_ONE) - a2 / 2 + a4 / 24 - a6 / 720;
      vlpa_trig = {16'(c), 16'(s)};
   endfunction

   // saturate to an eight bit code
   function automatic logic [7:0] vlpa_clamp(input logic signed [31:0] v);
      if (v < 0) begin
         vlpa_clamp = 8'h00;
      end else if (v > 255) begin
         vlpa_clamp = 8'hff;
      end else begin
         vlpa_clamp = v[7:0];
      end
   endfunction

   // register writes
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         luma_gain_q             <= VLPA_LUMA_GAIN_RST;
         luma_offset_q           <= VLPA_LUMA_OFFSET_RST;
         chroma_phase_q          <= VLPA_CHROMA_PHASE_RST;
         fallback_luma_q         <= VLPA_FALLBACK_LUMA_RST;   // [RULE18]
         fallback_chroma_q       <= VLPA_FALLBACK_CHROMA_RST; // [RULE20]
         lock_qualify_q          <= VLPA_LOCK_QUALIFY_RST;
         cb_offset_q             <= VLPA_CHROMA_OFFSET_RST;
         cr_offset_q             <= VLPA_CHROMA_OFFSET_RST;
         cb_gain_q               <= VLPA_CHROMA_GAIN_RST;
         cr_gain_q               <= VLPA_CHROMA_GAIN_RST;
         vertical_freerun_rate_q <= VLPA_VERT_COAST_RST;
      end else if (i_reg_wr) begin
         case (i_reg_addr)
            VLPA_LUMA_GAIN_OFS:       luma_gain_q       <= i_reg_wdata;
            VLPA_LUMA_OFFSET_OFS:     luma_offset_q     <= i_reg_wdata;
            VLPA_CHROMA_PHASE_OFS:    chroma_phase_q    <= i_reg_wdata;
            VLPA_FALLBACK_LUMA_OFS:   fallback_luma_q   <= i_reg_wdata;
            VLPA_FALLBACK_CHROMA_OFS: fallback_chroma_q <= i_reg_wdata;
            VLPA_LOCK_QUALIFY_OFS:    lock_qualify_q    <= i_reg_wdata;
            VLPA_CB_OFFSET_OFS:       cb_offset_q       <= i_reg_wdata;
            VLPA_CR_OFFSET_OFS:       cr_offset_q       <= i_reg_wdata;
            VLPA_CB_GAIN_OFS:         cb_gain_q         <= i_reg_wdata;
            VLPA_CR_GAIN_OFS:         cr_gain_q         <= i_reg_wdata;
            VLPA_VERT_COAST_OFS: begin
               vertical_freerun_rate_q <= i_reg_wdata[VLPA_COAST_RATE_LSB +: 2];
            end
            default: begin
            end
         endcase
      end
   end

   // field extraction
   assign subcarrier_lock_include = lock_qualify_q[VLPA_SC_LOCK_INCLUDE_BIT];
   assign raw_lock_source_select  = lock_qualify_q[VLPA_RAW_LOCK_SEL_BIT];
   assign fallback_auto_enable    = fallback_luma_q[VLPA_FALLBACK_AUTO_BIT];
   assign fallback_force_enable   = fallback_luma_q[VLPA_FALLBACK_FORCE_BIT];
   assign fallback_luma           = fallback_luma_q[VLPA_FALLBACK_LUMA_LSB +: 6];

   // lock qualification; component input relies on software clearing the include bit
   assign horizontal_lock_flag = raw_lock_source_select ? i_time_win : i_free_run; // [RULE21]
   assign lock_cond = horizontal_lock_flag && (!subcarrier_lock_include || i_sc_lock); // [RULE1] [RULE2] [RULE3]

   vlpa_lock_filter u_lock_filter (
      .i_clock      (i_clock),
      .i_rst_n      (i_rst_n),
      .i_line       (i_line),
      .i_cond       (lock_cond),
      .i_entry_code (lock_qualify_q[VLPA_ENTRY_COUNT_LSB +: 3]),
      .i_exit_code  (lock_qualify_q[VLPA_EXIT_COUNT_LSB +: 3]),
      .o_locked     (locked)
   );

   assign o_locked     = locked;
   assign fallback_sel = fallback_force_enable || (fallback_auto_enable && !locked); // [RULE16]

   // read path
   assign status_val = {4'h0, fallback_sel, i_sc_lock, horizontal_lock_flag, locked};

   always_comb begin
      case (i_reg_addr)
         VLPA_LUMA_GAIN_OFS:       rdata_d = luma_gain_q;
         VLPA_LUMA_OFFSET_OFS:     rdata_d = luma_offset_q;
         VLPA_CHROMA_PHASE_OFS:    rdata_d = chroma_phase_q;
         VLPA_FALLBACK_LUMA_OFS:   rdata_d = fallback_luma_q;
         VLPA_FALLBACK_CHROMA_OFS: rdata_d = fallback_chroma_q;
         VLPA_LOCK_STATUS_OFS:     rdata_d = status_val;
         VLPA_LOCK_QUALIFY_OFS:    rdata_d = lock_qualify_q;
         VLPA_CB_OFFSET_OFS:       rdata_d = cb_offset_q;
         VLPA_CR_OFFSET_OFS:       rdata_d = cr_offset_q;
         VLPA_CB_GAIN_OFS:         rdata_d = cb_gain_q;
         VLPA_CR_GAIN_OFS:         rdata_d = cr_gain_q;
         VLPA_VERT_COAST_OFS:      rdata_d = {4'h0, vertical_freerun_rate_q, 2'h0};
         default:                  rdata_d = 8'h00;
      endcase
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_reg_rdata  <= 8'h00;
         o_reg_rvalid <= 1'b0;
      end else begin
         o_reg_rvalid <= i_reg_rd;
         if (i_reg_rd) begin
            o_reg_rdata <= rdata_d;
         end
      end
   end

   // vertical coast rate; the reserved code behaves as auto
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_vs_rate_50 <= 1'b0;
      end else begin
         case (vertical_freerun_rate_q)
            VLPA_COAST_50HZ: o_vs_rate_50 <= 1'b1;           // [RULE4]
            VLPA_COAST_60HZ: o_vs_rate_50 <= 1'b0;           // [RULE4]
            default:         o_vs_rate_50 <= i_last_rate_50; // [RULE4]
         endcase
      end
   end

   // picture adjustment
   assign trig  = vlpa_trig(chroma_phase_q); // [RULE14]
   assign cos_v = 32'(signed'(trig[31:16]));
   assign sin_v = 32'(signed'(trig[15:0]));

   always_comb begin
      cb_c = signed'(32'(i_cb)) - VLPA_CHROMA_MID;
      cr_c = signed'(32'(i_cr)) - VLPA_CHROMA_MID;
      if (i_am_chroma) begin
         cb_r = (cb_c * cos_v + cr_c * sin_v) >>> VLPA_TRIG_SHIFT; // [RULE14]
         cr_r = (cr_c * cos_v - cb_c * sin_v) >>> VLPA_TRIG_SHIFT;
      end else begin
         cb_r = cb_c; // [RULE15]
         cr_r = cr_c;
      end
      y_s  = ((signed'(32'(i_y)) * signed'(32'(luma_gain_q))) >>> VLPA_GAIN_SHIFT)      // [RULE8]
             + ((32'(signed'(luma_offset_q)) * VLPA_LUMA_OFS_MUL) >>> VLPA_LUMA_OFS_SHIFT); // [RULE13]
      cb_s = ((cb_r * signed'(32'(cb_gain_q))) >>> VLPA_GAIN_SHIFT) + signed'(32'(cb_offset_q)); // [RULE9] [RULE11]
      cr_s = ((cr_r * signed'(32'(cr_gain_q))) >>> VLPA_GAIN_SHIFT) + signed'(32'(cr_offset_q)); // [RULE10] [RULE12]
      y_d  = vlpa_clamp(y_s);
      cb_d = vlpa_clamp(cb_s);
      cr_d = vlpa_clamp(cr_s);
   end

   // output stage with fallback substitution
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_valid <= 1'b0;
         o_y     <= 8'h00;
         o_cb    <= 8'h00;
         o_cr    <= 8'h00;
      end else begin
         o_valid <= i_valid;
         if (i_valid) begin
            if (fallback_sel) begin
               o_y  <= {fallback_luma, 2'h0};              // [RULE16] [RULE17]
               o_cr <= {fallback_chroma_q[7:4], 4'h0};     // [RULE19]
               o_cb <= {fallback_chroma_q[3:0], 4'h0};     // [RULE19]
            end else begin
               o_y  <= y_d;
               o_cb <= cb_d;
               o_cr <= cr_d;
            end
         end
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_fallback_active <= 1'b0;
      end else begin
         o_fallback_active <= fallback_sel;
      end
   end

   lock_include_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RULE1]
      (!lock_qualify_q[VLPA_SC_LOCK_INCLUDE_BIT]) |-> (lock_cond == horizontal_lock_flag))
      else $error("lock condition depends on subcarrier while excluded");

   sc_lock_gate_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RULE2]
      (lock_qualify_q[VLPA_SC_LOCK_INCLUDE_BIT] && !i_sc_lock) |-> !lock_cond)
      else $error("lock condition true without subcarrier lock");

   raw_source_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RULE21]
      (!lock_qualify_q[VLPA_SC_LOCK_INCLUDE_BIT])
      |-> (lock_cond == (lock_qualify_q[VLPA_RAW_LOCK_SEL_BIT] ? i_time_win : i_free_run)))
      else $error("wrong raw lock source");

   coast_rate_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RULE4]
      (vertical_freerun_rate_q == VLPA_COAST_50HZ) ##1 (vertical_freerun_rate_q == VLPA_COAST_50HZ)
      |-> o_vs_rate_50)
      else $error("forced 50 Hz coast not applied");

   fallback_force_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RULE16]
      (i_valid && fallback_luma_q[VLPA_FALLBACK_FORCE_BIT])
      |=> (o_y == {$past(fallback_luma_q[7:2]), 2'h0}) && o_fallback_active)
      else $error("forced fallback luma not output");

   fallback_chroma_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RULE19]
      (i_valid && fallback_luma_q[VLPA_FALLBACK_AUTO_BIT] && !o_locked)
      |=> (o_cr == {$past(fallback_chroma_q[7:4]), 4'h0}) && (o_cb == {$past(fallback_chroma_q[3:0]), 4'h0}))
      else $error("fallback chroma not output while unlocked");

   luma_unity_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RULE8]
      (i_valid && !fallback_sel && luma_gain_q == 8'h80 && luma_offset_q == 8'h00)
      |=> (o_y == $past(i_y)))
      else $error("unity luma gain altered the sample");

   luma_offset_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RULE13]
      (i_valid && !fallback_sel && luma_gain_q == 8'h00 && luma_offset_q == 8'h7f)
      |=> (o_y == 8'hde))
      else $error("positive luma offset wrong");

   chroma_neutral_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RULE11]
      (i_valid && !fallback_sel && chroma_phase_q == 8'h00 && cb_gain_q == 8'h80 && cb_offset_q == 8'h80)
      |=> (o_cb == $past(i_cb)))
      else $error("neutral Cb settings altered the sample");

   cr_gain_only_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RULE10]
      (i_valid && !fallback_sel && !i_am_chroma && cr_gain_q == 8'h00 && cr_offset_q == 8'h80)
      |=> (o_cr == 8'h80))
      else $error("zero Cr gain did not null Cr");

   phase_bypass_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RULE15]
      (i_valid && !fallback_sel && !i_am_chroma && cb_gain_q == 8'h80 && cb_offset_q == 8'h80)
      |=> (o_cb == $past(i_cb)))
      else $error("phase rotation touched non-AM chroma");

endmodule

/* tb.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; \
   $display("[FAIL] %0t mismatch got %h exp %h", $time, a, b); end end
module tb;
   import vlpa_pkg::*;
   logic        i_clock = 1'b0;
   logic        i_rst_n = 1'b0;
   logic [7:0]  i_reg_addr = 8'h00, i_reg_wdata = 8'h00, i_y = 8'h00, i_cb = 8'h80, i_cr = 8'h80;
   logic        i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_line = 1'b0, i_time_win = 1'b0, i_free_run = 1'b0;
   logic        i_sc_lock = 1'b0, i_last_rate_50 = 1'b0, i_valid = 1'b0, i_am_chroma = 1'b0;
   logic [7:0]  o_reg_rdata, o_y, o_cb, o_cr;
   logic        o_reg_rvalid, o_valid, o_locked, o_fallback_active, o_vs_rate_50;
   logic [31:0] seed = 32'h6daa684b;
   int          fails = 0, checks_done = 0, cycles = 0;
   logic [7:0]  rst_addr [12] = '{8'h08, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h51, 8'he1, 8'he2, 8'he3, 8'he4, 8'hf9, 8'h33};
   logic [7:0]  rst_val [12] = '{8'h80, 8'h00, 8'h00, 8'h36, 8'h7c, 8'h24, 8'h80, 8'h80, 8'h80, 8'h80, 8'h00, 8'h00};
   logic [7:0]  gtab [4] = '{8'h80, 8'h00, 8'hff, 8'h40};
   logic [7:0]  otab [4] = '{8'h00, 8'h7f, 8'hff, 8'h10};
   logic [7:0]  yv;

   vlpa_core dut_u (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
      .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
      .i_line(i_line), .i_time_win(i_time_win), .i_free_run(i_free_run), .i_sc_lock(i_sc_lock),
      .i_last_rate_50(i_last_rate_50), .i_valid(i_valid), .i_am_chroma(i_am_chroma), .i_y(i_y), .i_cb(i_cb),
      .i_cr(i_cr), .o_valid(o_valid), .o_y(o_y), .o_cb(o_cb), .o_cr(o_cr), .o_locked(o_locked),
      .o_fallback_active(o_fallback_active), .o_vs_rate_50(o_vs_rate_50));

   initial begin
      forever #5 i_clock = ~i_clock;
   end

   task automatic tally_and_finish();
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   always @(posedge i_clock) begin
      cycles++;
      if (cycles == 2000) begin
         fails++;
         tally_and_finish();
      end
   end

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [7:0] exp_y(input logic [7:0] y, input logic [7:0] g, input logic [7:0] o);
      int t;
      t = ((int'(y) * int'(g)) >>> 7) + ((int'($signed(o)) * 7) >>> 2);
      exp_y = (t < 0) ? 8'h00 : (t > 255) ? 8'hff : t[7:0];
   endfunction

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clock) #1 i_reg_addr = a;
      i_reg_wdata = d;
      i_reg_wr = 1'b1;
      @(posedge i_clock) #1 i_reg_wr = 1'b0;
   endtask

   task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge i_clock) #1 i_reg_addr = a;
      i_reg_rd = 1'b1;
      @(posedge i_clock) #1 i_reg_rd = 1'b0;
      `CHK(o_reg_rvalid, 1'b1)
      `CHK(o_reg_rdata, e)
   endtask

   task automatic lines(input int n, input logic e);
      repeat (n) begin
         @(posedge i_clock) #1 i_line = 1'b1;
         @(posedge i_clock) #1 i_line = 1'b0;
      end
      `CHK(o_locked, e)
   endtask

   task automatic vid(input logic [7:0] y, cb, cr, ey, ecb, ecr);
      @(posedge i_clock) #1 i_y = y;
      i_cb = cb;
      i_cr = cr;
      i_valid = 1'b1;
      @(posedge i_clock) #1 i_valid = 1'b0;
      `CHK(o_valid, 1'b1)
      `CHK({o_y, o_cb, o_cr}, {ey, ecb, ecr})
   endtask

   initial begin
      repeat (16) @(posedge i_clock);
      #1 i_rst_n = 1'b1;
      repeat (2) @(posedge i_clock);
      vid(8'h40, 8'h11, 8'h22, 8'h34, 8'hc0, 8'h70);
      `CHK(o_fallback_active, 1'b1)
      for (int i = 0; i < 12; i++)
         reg_rd(rst_addr[i], rst_val[i]);
      i_time_win = 1'b1;
      reg_wr(8'h51, 8'h51);
      lines(1, 1'b0);
      lines(1, 1'b1);
      reg_rd(8'h10, {4'h0, 1'b0, 1'b0, 1'b1, 1'b1});
      reg_wr(8'h51, 8'hd1);
      lines(4, 1'b1);
      i_sc_lock = 1'b1;
      lines(1, 1'b1);
      i_sc_lock = 1'b0;
      lines(4, 1'b1);
      lines(1, 1'b0);
      i_sc_lock = 1'b1;
      lines(2, 1'b1);
      reg_wr(8'h51, 8'h11);
      lines(5, 1'b0);
      i_free_run = 1'b1;
      lines(2, 1'b1);
      for (int i = 0; i < 4; i++) begin
         reg_wr(8'h08, gtab[i]);
         reg_wr(8'h0a, otab[i]);
         for (int j = 0; j < 4; j++) begin
            seed = lfsr_next(seed);
            yv = (j == 0) ? 8'hff : seed[7:0];
            vid(yv, seed[15:8], seed[23:16], exp_y(yv, gtab[i], otab[i]), seed[15:8], seed[23:16]);
         end
      end
      // back to unity luma so the chroma scenarios see luma unchanged
      reg_wr(8'h08, 8'h80);
      reg_wr(8'h0a, 8'h00);
      reg_wr(8'he1, 8'h90);
      vid(8'h20, 8'h50, 8'h50, 8'h20, 8'h60, 8'h50);
      vid(8'h20, 8'hf8, 8'h50, 8'h20, 8'hff, 8'h50);
      reg_wr(8'he1, 8'h80);
      reg_wr(8'he2, 8'h00);
      vid(8'h20, 8'h50, 8'h50, 8'h20, 8'h50, 8'h00);
      reg_wr(8'he2, 8'h80);
      reg_wr(8'he4, 8'h00);
      vid(8'h20, 8'h30, 8'hd0, 8'h20, 8'h30, 8'h80);
      reg_wr(8'he4, 8'h80);
      reg_wr(8'he3, 8'h00);
      vid(8'h20, 8'h30, 8'hd0, 8'h20, 8'h80, 8'hd0);
      reg_wr(8'he3, 8'h80);
      reg_wr(8'h0b, 8'h80);
      vid(8'h20, 8'hc0, 8'h80, 8'h20, 8'hc0, 8'h80);
      i_am_chroma = 1'b1;
      @(posedge i_clock) #1 i_y = 8'h20;
      i_cb = 8'hc0;
      i_cr = 8'h80;
      i_valid = 1'b1;
      @(posedge i_clock) #1 i_valid = 1'b0;
      `CHK(o_valid, 1'b1)
      `CHK(o_y, 8'h20)
      `CHK(o_cb inside {[8'h7d:8'h83]}, 1'b1)
      `CHK(o_cr inside {[8'h3d:8'h43], [8'hbd:8'hc3]}, 1'b1)
      reg_wr(8'h0b, 8'h00);
      vid(8'h20, 8'hc0, 8'h40, 8'h20, 8'hc0, 8'h40);
      for (int k = 0; k < 4; k++) begin
         reg_wr(8'hf9, {4'hf, k[1:0], 2'h3});
         reg_rd(8'hf9, {4'h0, k[1:0], 2'h0});
         for (int r = 0; r < 2; r++) begin
            i_last_rate_50 = r[0];
            repeat (3) @(posedge i_clock);
            `CHK(o_vs_rate_50, (k == 1) ? 1'b1 : (k == 2) ? 1'b0 : r[0])
         end
      end
      reg_wr(8'h0c, 8'ha9);
      reg_wr(8'h0d, 8'h5e);
      vid(8'h20, 8'h30, 8'h30, 8'ha8, 8'he0, 8'h50);
      `CHK(o_fallback_active, 1'b1)
      tally_and_finish();
   end
endmodule
